// [rtl/pcis_cfg.svh]
// constants for the pin control and interrupt status block
// assumes registers reached by word index, byte address = index * 4
`ifndef PCIS_CFG_SVH
`define PCIS_CFG_SVH

// ****************************************
// register indices
// ****************************************
`define PCIS_IDX_W          8
`define PCIS_IDX_LSB        2
`define PCIS_IDX_PIN_CFG    8'h0b
`define PCIS_IDX_PIN_B_CTRL 8'h0e
`define PCIS_IDX_STATUS     8'h10
`define PCIS_IDX_IRQ_CFG    8'h12
`define PCIS_IDX_MASK       8'h13

// ****************************************
// field positions
// ****************************************
`define PCIS_DIR_BIT        15
`define PCIS_PULL_HI        14
`define PCIS_PULL_LO        13
`define PCIS_MODE_BIT       12
`define PCIS_INV_BIT        10
`define PCIS_LVL_BIT        5
`define PCIS_FN_HI          3
`define PCIS_FN_LO          0
`define PCIS_ST_TEMP        15
`define PCIS_ST_PIN_B       13
`define PCIS_ST_PIN_A       12
`define PCIS_ST_REG_LOW     0
`define PCIS_SEL_BIT        0
`define PCIS_REQ_MASK_BIT   0
`define PCIS_REG_W          16

// ****************************************
// reset values and encodings
// ****************************************
`define PCIS_DIR_RST        1'b1
`define PCIS_PULL_RST       2'b10
`define PCIS_PULL_DOWN      2'b01
`define PCIS_PULL_UP        2'b10
`define PCIS_FN_RST         4'h0
`define PCIS_REQ_MASK_RST   1'b1
`define PCIS_RESP_OKAY      2'b00
`define PCIS_RESP_SLVERR    2'b10

`endif

// [rtl/pcis_pkg.sv]
// types shared by the pin control and interrupt status block
// assumes pcis_cfg.svh supplies the numeric constants
package pcis_pkg;

    // pin role codes
    typedef enum logic [3:0] {
        PCIS_FN_LOGIC_IN  = 4'h0,
        PCIS_FN_EDGE_IN   = 4'h1,
        PCIS_FN_CLOCK_OUT = 4'h2,
        PCIS_FN_IRQ_OUT   = 4'h3,
        PCIS_FN_TEMP_OUT  = 4'h7,
        PCIS_FN_DMIC_CLK  = 4'h9,
        PCIS_FN_LOGIC_OUT = 4'ha,
        PCIS_FN_REG_LOW   = 4'hb
    } pcis_fn_e;

    typedef enum logic [2:0] {
        PCIS_BUS_IDLE = 3'b001,
        PCIS_BUS_TAKE = 3'b010,
        PCIS_BUS_RESP = 3'b100
    } pcis_bus_e;

endpackage : pcis_pkg

// [rtl/pcis_sync.sv]
// two flop synchroniser for asynchronous levels
// assumes inputs may change at any time relative to clk
`timescale 1ns/1ps
module pcis_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // levels
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta;

    // meta feeds only the second stage
    always_ff @(posedge clk) begin
        if (rst) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end

endmodule : pcis_sync

// [rtl/pcis_flag.sv]
// sticky event flag, cleared by a status read
// assumes set and clear are single-clock signals in the clk domain
`timescale 1ns/1ps
module pcis_flag (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // control
    input  wire logic set,
    input  wire logic clear,
    output logic      flag
);

    // set wins so an event in the read cycle is not lost
    always_ff @(posedge clk) begin
        if (rst) begin
            flag <= 1'b0;
        end else begin
            flag <= set | (flag & ~clear);
        end
    end

endmodule : pcis_flag

// [rtl/pcis_top.sv]
// second general pin control and system interrupt status, AXI4-Lite slave
// assumes one clock, synchronous reset, pin and alert inputs asynchronous
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`include "pcis_cfg.svh"
module pcis_top
    import pcis_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input  wire logic              CLK,
    input  wire logic              SYS_RST,
    // axi4-lite write address and data
    input  wire logic [ADDR_W-1:0] AWADDR,
    input  wire logic              AWVALID,
    output logic                   AWREADY,
    input  wire logic [31:0]       WDATA,
    input  wire logic [3:0]        WSTRB,
    input  wire logic              WVALID,
    output logic                   WREADY,
    // axi4-lite write response
    output logic [1:0]             BRESP,
    output logic                   BVALID,
    input  wire logic              BREADY,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0] ARADDR,
    input  wire logic              ARVALID,
    output logic                   ARREADY,
    output logic [31:0]            RDATA,
    output logic [1:0]             RRESP,
    output logic                   RVALID,
    input  wire logic              RREADY,
    // second general pin pad
    input  wire logic              PIN_B_IN,
    output logic                   PIN_B_OUT,
    output logic                   PIN_B_OE,
    output logic                   PIN_B_PULL_UP,
    output logic                   PIN_B_PULL_DOWN,
    // event sources and role signals
    input  wire logic              TEMP_ALERT,
    input  wire logic              REG_LOW_ALERT,
    input  wire logic              PIN_A_EVENT,
    input  wire logic              CLK_OUT_SRC,
    input  wire logic              DMIC_CLK_SRC,
    // interrupt request
    output logic                   IRQ
);

    // ****************************************
    // register state
    // ****************************************
    logic                     pin_b_direction;
    logic [1:0]               pin_b_pull_select;
    logic                     pin_b_edge_mode;
    logic                     pin_b_invert;
    logic                     pin_b_level;
    logic [3:0]               pin_b_function;
    logic                     pin_select;
    logic                     request_output_mask;
    logic                     mask_temp;
    logic                     pin_b_event_mask;
    logic                     mask_pin_a;
    logic                     mask_reg_low;
    pcis_bus_e                wr_state;
    pcis_bus_e                rd_state;

    // ****************************************
    // decode and synchronisers
    // ****************************************
    logic [`PCIS_IDX_W-1:0]   wr_idx;
    logic [`PCIS_IDX_W-1:0]   rd_idx;
    logic                     wr_en;
    logic                     rd_en;
    logic                     wr_lo;
    logic                     wr_hi;
    logic                     status_clear;
    logic [2:0]               sync_out;
    logic                     pin_sync;
    logic                     temp_sync;
    logic                     reg_low_sync;
    logic                     pin_prev;
    logic                     temp_prev;
    logic                     reg_low_prev;

    assign wr_idx       = AWADDR[`PCIS_IDX_LSB +: `PCIS_IDX_W];
    assign rd_idx       = ARADDR[`PCIS_IDX_LSB +: `PCIS_IDX_W];
    assign wr_en        = (wr_state == PCIS_BUS_TAKE);
    assign rd_en        = (rd_state == PCIS_BUS_TAKE);
    assign wr_lo        = wr_en & WSTRB[0];
    assign wr_hi        = wr_en & WSTRB[1];
    assign status_clear = rd_en & (rd_idx == `PCIS_IDX_STATUS);

    pcis_sync #(
        .WIDTH (3)
    ) u_sync (
        .clk  (CLK),
        .rst  (SYS_RST),
        .din  ({PIN_B_IN, TEMP_ALERT, REG_LOW_ALERT}),
        .dout (sync_out)
    );
    assign pin_sync     = sync_out[2];
    assign temp_sync    = sync_out[1];
    assign reg_low_sync = sync_out[0];

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            pin_prev     <= 1'b0;
            temp_prev    <= 1'b0;
            reg_low_prev <= 1'b0;
        end else begin
            pin_prev     <= pin_sync;
            temp_prev    <= temp_sync;
            reg_low_prev <= reg_low_sync;
        end
    end

    // ****************************************
    // pin control register
    // ****************************************
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            pin_b_direction   <= `PCIS_DIR_RST;
            pin_b_pull_select <= `PCIS_PULL_RST;
            pin_b_edge_mode   <= 1'b0;
            pin_b_invert      <= 1'b0;
            pin_b_level       <= 1'b0;
            pin_b_function    <= `PCIS_FN_RST;
        end else if (wr_idx == `PCIS_IDX_PIN_B_CTRL) begin
            if (wr_hi) begin
                pin_b_direction   <= WDATA[`PCIS_DIR_BIT];
                pin_b_pull_select <= WDATA[`PCIS_PULL_HI:`PCIS_PULL_LO];
                pin_b_edge_mode   <= WDATA[`PCIS_MODE_BIT];
                pin_b_invert      <= WDATA[`PCIS_INV_BIT];
            end
            if (wr_lo) begin
                pin_b_level    <= WDATA[`PCIS_LVL_BIT];
                pin_b_function <= WDATA[`PCIS_FN_HI:`PCIS_FN_LO];
            end
        end
    end

    // the select bit only ever goes to one; reset alone returns it
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            pin_select <= 1'b0;
        end else if (wr_lo && wr_idx == `PCIS_IDX_PIN_CFG && WDATA[`PCIS_SEL_BIT]) begin
            pin_select <= 1'b1;
        end
    end

    // ****************************************
    // mask registers
    // ****************************************
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            request_output_mask <= `PCIS_REQ_MASK_RST;
        end else if (wr_lo && wr_idx == `PCIS_IDX_IRQ_CFG) begin
            request_output_mask <= WDATA[`PCIS_REQ_MASK_BIT];
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            mask_temp        <= 1'b0;
            pin_b_event_mask <= 1'b0;
            mask_pin_a       <= 1'b0;
            mask_reg_low     <= 1'b0;
        end else if (wr_idx == `PCIS_IDX_MASK) begin
            if (wr_hi) begin
                mask_temp        <= WDATA[`PCIS_ST_TEMP];
                pin_b_event_mask <= WDATA[`PCIS_ST_PIN_B];
                mask_pin_a       <= WDATA[`PCIS_ST_PIN_A];
            end
            if (wr_lo) begin
                mask_reg_low <= WDATA[`PCIS_ST_REG_LOW];
            end
        end
    end

    // ****************************************
    // edge detection and sticky flags
    // ****************************************
    logic       lvl_now;
    logic       lvl_prev;
    logic       pin_rise;
    logic       pin_fall;
    logic       pin_b_edge;
    logic [3:0] flag_set;
    logic [3:0] flags;
    logic [3:0] flag_mask;
    logic       irq_req;

    // edges seen after inversion; both samples use the current invert bit, so toggling it fakes none
    assign lvl_now  = pin_sync ^ pin_b_invert;
    assign lvl_prev = pin_prev ^ pin_b_invert;
    assign pin_rise = lvl_now & ~lvl_prev;
    assign pin_fall = ~lvl_now & lvl_prev;
    assign pin_b_edge = pin_select && pin_b_function == PCIS_FN_EDGE_IN
                        && (pin_b_edge_mode ? (pin_rise | pin_fall)
                                            : pin_rise);

    // order: regulator low, first pin, second pin, thermal
    assign flag_set  = {temp_sync & ~temp_prev, pin_b_edge, PIN_A_EVENT,
                        reg_low_sync & ~reg_low_prev};
    assign flag_mask = {mask_temp, pin_b_event_mask, mask_pin_a, mask_reg_low};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_flag
            pcis_flag u_flag (
                .clk   (CLK),
                .rst   (SYS_RST),
                .set   (flag_set[gi]),
                .clear (status_clear),
                .flag  (flags[gi])
            );
        end
    endgenerate

    assign irq_req = ~request_output_mask & |(flags & ~flag_mask);

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= irq_req;
        end
    end

    // ****************************************
    // pad drive
    // ****************************************
    // role clocks are retimed, so they reach the pad one cycle late
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            PIN_B_OUT <= 1'b0;
        end else begin
            case (pin_b_function)
                PCIS_FN_LOGIC_OUT: PIN_B_OUT <= pin_b_level ^ pin_b_invert;
                PCIS_FN_CLOCK_OUT: PIN_B_OUT <= CLK_OUT_SRC ^ pin_b_invert;
                PCIS_FN_IRQ_OUT:   PIN_B_OUT <= irq_req ^ pin_b_invert;
                PCIS_FN_TEMP_OUT:  PIN_B_OUT <= temp_sync ^ pin_b_invert;
                PCIS_FN_DMIC_CLK:  PIN_B_OUT <= DMIC_CLK_SRC ^ pin_b_invert;
                PCIS_FN_REG_LOW:   PIN_B_OUT <= reg_low_sync ^ pin_b_invert;
                default:           PIN_B_OUT <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            PIN_B_OE        <= 1'b0;
            PIN_B_PULL_UP   <= 1'b0;
            PIN_B_PULL_DOWN <= 1'b0;
        end else begin
            PIN_B_OE        <= pin_select & ~pin_b_direction;
            PIN_B_PULL_UP   <= pin_select & (pin_b_pull_select == `PCIS_PULL_UP);
            PIN_B_PULL_DOWN <= pin_select & (pin_b_pull_select == `PCIS_PULL_DOWN);
        end
    end

    // ****************************************
    // axi4-lite write channel
    // ****************************************
    // address and data are taken together; the slave waits for both
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            wr_state <= PCIS_BUS_IDLE;
            AWREADY  <= 1'b0;
            WREADY   <= 1'b0;
            BVALID   <= 1'b0;
            BRESP    <= `PCIS_RESP_OKAY;
        end else begin
            case (wr_state)
                PCIS_BUS_IDLE: if (AWVALID && WVALID) begin
                    AWREADY  <= 1'b1;
                    WREADY   <= 1'b1;
                    wr_state <= PCIS_BUS_TAKE;
                end
                PCIS_BUS_TAKE: begin
                    AWREADY  <= 1'b0;
                    WREADY   <= 1'b0;
                    BVALID   <= 1'b1;
                    // status is read-only, so a write there is an error
                    BRESP    <= (wr_idx == `PCIS_IDX_PIN_B_CTRL || wr_idx == `PCIS_IDX_PIN_CFG
                                 || wr_idx == `PCIS_IDX_IRQ_CFG || wr_idx == `PCIS_IDX_MASK)
                                ? `PCIS_RESP_OKAY : `PCIS_RESP_SLVERR;
                    wr_state <= PCIS_BUS_RESP;
                end
                PCIS_BUS_RESP: if (BREADY) begin
                    BVALID   <= 1'b0;
                    wr_state <= PCIS_BUS_IDLE;
                end
                default: wr_state <= PCIS_BUS_IDLE;
            endcase
        end
    end

    // ****************************************
    // axi4-lite read channel
    // ****************************************
    logic [`PCIS_REG_W-1:0] ctrl_view;
    logic [`PCIS_REG_W-1:0] status_view;

    always_comb begin
        ctrl_view                              = '0;
        ctrl_view[`PCIS_DIR_BIT]               = pin_b_direction;
        ctrl_view[`PCIS_PULL_HI:`PCIS_PULL_LO] = pin_b_pull_select;
        ctrl_view[`PCIS_MODE_BIT]              = pin_b_edge_mode;
        ctrl_view[`PCIS_INV_BIT]               = pin_b_invert;
        ctrl_view[`PCIS_LVL_BIT]               = lvl_now;
        ctrl_view[`PCIS_FN_HI:`PCIS_FN_LO]     = pin_b_function;
    end

    always_comb begin
        status_view                     = '0;
        status_view[`PCIS_ST_TEMP]      = flags[3];
        status_view[`PCIS_ST_PIN_B]     = flags[2];
        status_view[`PCIS_ST_PIN_A]     = flags[1];
        status_view[`PCIS_ST_REG_LOW]   = flags[0];
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            rd_state <= PCIS_BUS_IDLE;
            ARREADY  <= 1'b0;
            RVALID   <= 1'b0;
            RDATA    <= '0;
            RRESP    <= `PCIS_RESP_OKAY;
        end else begin
            case (rd_state)
                PCIS_BUS_IDLE: if (ARVALID) begin
                    ARREADY  <= 1'b1;
                    rd_state <= PCIS_BUS_TAKE;
                end
                PCIS_BUS_TAKE: begin
                    ARREADY  <= 1'b0;
                    RVALID   <= 1'b1;
                    RRESP    <= `PCIS_RESP_OKAY;
                    RDATA    <= '0;
                    case (rd_idx)
                        `PCIS_IDX_PIN_B_CTRL: RDATA[`PCIS_REG_W-1:0] <= ctrl_view;
                        `PCIS_IDX_STATUS:     RDATA[`PCIS_REG_W-1:0] <= status_view;
                        `PCIS_IDX_PIN_CFG:    RDATA[`PCIS_SEL_BIT] <= pin_select;
                        `PCIS_IDX_IRQ_CFG:    RDATA[`PCIS_REQ_MASK_BIT] <= request_output_mask;
                        `PCIS_IDX_MASK: begin
                            RDATA[`PCIS_ST_TEMP]    <= mask_temp;
                            RDATA[`PCIS_ST_PIN_B]   <= pin_b_event_mask;
                            RDATA[`PCIS_ST_PIN_A]   <= mask_pin_a;
                            RDATA[`PCIS_ST_REG_LOW] <= mask_reg_low;
                        end
                        default: RRESP <= `PCIS_RESP_SLVERR;
                    endcase
                    rd_state <= PCIS_BUS_RESP;
                end
                PCIS_BUS_RESP: if (RREADY) begin
                    RVALID   <= 1'b0;
                    rd_state <= PCIS_BUS_IDLE;
                end
                default: rd_state <= PCIS_BUS_IDLE;
            endcase
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    a_pull_decode: assert property (
        PIN_B_PULL_UP |-> $past(pin_select && pin_b_pull_select == `PCIS_PULL_UP))
        else $error("pull-up enabled without pull-up code");
    a_single_edge: assert property (
        (pin_select && pin_b_function == PCIS_FN_EDGE_IN && !pin_b_edge_mode
         && !pin_b_invert && pin_sync && !pin_prev) |=> flags[2])
        else $error("rising edge did not set second pin flag");
    a_fall_ignored: assert property (
        (!pin_b_edge_mode && !pin_b_invert && !flags[2] && !pin_sync && pin_prev)
        |=> !flags[2])
        else $error("falling edge set flag in single edge mode");
    a_both_edges: assert property (
        (pin_select && pin_b_function == PCIS_FN_EDGE_IN && pin_b_edge_mode
         && (pin_sync != pin_prev)) |=> flags[2])
        else $error("edge missed in both edge mode");
    a_logic_drive: assert property (
        (pin_b_function == PCIS_FN_LOGIC_OUT) |=> PIN_B_OUT == $past(pin_b_level ^ pin_b_invert))
        else $error("logic output level wrong");
    a_flag_hold: assert property (
        (flags[3] && !status_clear) |=> flags[3])
        else $error("thermal flag dropped without a read");
    a_read_clear: assert property (
        (status_clear && !flag_set[1]) |=> !flags[1])
        else $error("status read did not clear first pin flag");
    a_irq_gate: assert property (
        IRQ == $past(!request_output_mask && |(flags & ~flag_mask)))
        else $error("irq output disagrees with flags and masks");
    a_select_latch: assert property (
        pin_select |=> pin_select)
        else $error("pin select bit cleared without reset");
    a_oe_select: assert property (
        !pin_select |=> !PIN_B_OE)
        else $error("pin driven before being selected");
    a_bvalid_hold: assert property (
        BVALID |=> (BVALID && $stable(BRESP)) || $past(BREADY))
        else $error("write response dropped early");

    c_edge_flag:  cover property (pin_b_edge ##1 flags[2]);
    c_read_clear: cover property (status_clear && |flags);
    c_irq_raise:  cover property (!IRQ ##1 IRQ);
    c_logic_out:  cover property (PIN_B_OE && pin_b_function == PCIS_FN_LOGIC_OUT);

endmodule : pcis_top

// [sim/pcis_board.sv]
// board logic facing the second general pin
// assumes the bench sets ext_en and ext_val off the clock edge
`timescale 1ns/1ps
module pcis_board (
    // pad outputs of the block
    input  wire logic oe,
    input  wire logic drv,
    input  wire logic pu,
    input  wire logic pd,
    // board stimulus
    input  wire logic ext_en,
    input  wire logic ext_val,
    output logic      pad
);
    logic flt = 1'b0;

    // an undriven pad without pull wanders, so readback cannot rely on it
    always #7 flt = ~flt;
    always_comb pad = oe ? drv : ext_en ? ext_val : pu ? 1'b1 : pd ? 1'b0 : flt;
endmodule : pcis_board

// [sim/test_pcis_top.sv]
// self-checking bench for the pin control and interrupt status block
// assumes the block answers on AXI4-Lite and the pad is modelled by pcis_board
`timescale 1ns/1ps
`include "pcis_cfg.svh"
module test_pcis_top;
    logic        CLK = 0, SYS_RST = 1, AWVALID = 0, WVALID = 0, BREADY = 0;
    logic        ARVALID = 0, RREADY = 0, TEMP_ALERT = 0, REG_LOW_ALERT = 0;
    logic        PIN_A_EVENT = 0, CLK_OUT_SRC = 0, DMIC_CLK_SRC = 0, ext_en = 1, ext_val = 0;
    logic [11:0] AWADDR = 0, ARADDR = 0;
    logic [31:0] WDATA = 0, d, v;
    logic [3:0]  WSTRB = 0;
    logic [1:0]  BRESP, RRESP, src_q;
    logic [31:0] RDATA;
    logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, PIN_B_IN, PIN_B_OUT;
    logic        PIN_B_OE, PIN_B_PULL_UP, PIN_B_PULL_DOWN, IRQ, lvl, md, inv;
    int          n_errors = 0, n_checks = 0, seed = 32'hc8c8;

    pcis_top i_pcis_top (.CLK, .SYS_RST, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB,
        .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA,
        .RRESP, .RVALID, .RREADY, .PIN_B_IN, .PIN_B_OUT, .PIN_B_OE, .PIN_B_PULL_UP,
        .PIN_B_PULL_DOWN, .TEMP_ALERT, .REG_LOW_ALERT, .PIN_A_EVENT, .CLK_OUT_SRC,
        .DMIC_CLK_SRC, .IRQ);
    pcis_board i_pcis_board (.oe(PIN_B_OE), .drv(PIN_B_OUT), .pu(PIN_B_PULL_UP),
        .pd(PIN_B_PULL_DOWN), .ext_en(ext_en), .ext_val(ext_val), .pad(PIN_B_IN));

    always #5 CLK = ~CLK;
    always @(posedge CLK) begin
        CLK_OUT_SRC <= ~CLK_OUT_SRC;
        DMIC_CLK_SRC <= $random(seed);
        // role sources as the pad register saw them one edge back
        src_q <= {DMIC_CLK_SRC, CLK_OUT_SRC};
    end

    // ****************************************
    // bus tasks and comparison
    // ****************************************
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] x, input logic [1:0] r);
        logic aw, w;
        aw = 1;
        w = 1;
        AWADDR <= a;
        WDATA <= x;
        WSTRB <= 4'hf;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        do begin
            @(posedge CLK);
            if (aw && AWREADY === 1'b1) begin
                AWVALID <= 1'b0;
                aw = 0;
            end
            if (w && WREADY === 1'b1) begin
                WVALID <= 1'b0;
                w = 0;
            end
        end while (aw | w);
        do @(posedge CLK); while (BVALID !== 1'b1);
        BREADY <= 1'b0;
        chk(BRESP, r, "bresp");
        @(posedge CLK);
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] x, input logic [1:0] r);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do @(posedge CLK); while (ARREADY !== 1'b1);
        ARVALID <= 1'b0;
        do @(posedge CLK); while (RVALID !== 1'b1);
        x = RDATA;
        RREADY <= 1'b0;
        chk(RRESP, r, "rresp");
        @(posedge CLK);
    endtask : rd

    task automatic rds(input logic [15:0] e);
        rd(12'h040, d, 2'b00);
        chk(d, {16'h0, e}, "status");
    endtask : rds

    task test_done;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        repeat (4) @(posedge CLK);
        SYS_RST <= 1'b0;
        @(posedge CLK);
        rd(12'h038, d, 2'b00);
        chk(d, 32'h0000c000, "ctrl reset");
        rds(16'h0);
        wr(12'h040, 32'hffff, 2'b10);
        rd(12'h100, d, 2'b10);
        chk(d, 32'h0, "unmapped");
        wr(12'h02c, 32'h1, 2'b00);
        chk(PIN_B_PULL_UP, 1'b1, "pull up");
        // board lets go of the pad; the pull-up alone sets the level
        ext_en <= 1'b0;
        repeat (4) @(posedge CLK);
        rd(12'h038, d, 2'b00);
        chk(d, 32'h0000c020, "pull level");
        ext_en <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            inv = i[0];
            lvl = $random(seed);
            v = 32'h200a | (inv << 10) | (lvl << 5);
            wr(12'h038, v, 2'b00);
            repeat (4) @(posedge CLK);
            chk({PIN_B_OE, PIN_B_PULL_DOWN}, 2'b11, "drive");
            chk(PIN_B_OUT, lvl ^ inv, "pad out");
            rd(12'h038, d, 2'b00);
            chk(d, v, "level back");
        end
        // edges from config writes themselves are flushed before each check
        for (int k = 0; k < 4; k++) begin
            md = k[1];
            inv = k[0];
            ext_val <= 1'b0;
            wr(12'h038, 32'h8001 | (md << 12) | (inv << 10), 2'b00);
            repeat (8) @(posedge CLK);
            rd(12'h040, d, 2'b00);
            ext_val <= 1'b1;
            repeat (8) @(posedge CLK);
            rds({2'b0, md | ~inv, 13'h0});
            ext_val <= 1'b0;
            repeat (8) @(posedge CLK);
            rds({2'b0, md | inv, 13'h0});
        end
        TEMP_ALERT <= 1'b1;
        REG_LOW_ALERT <= 1'b1;
        PIN_A_EVENT <= 1'b1;
        @(posedge CLK);
        PIN_A_EVENT <= 1'b0;
        repeat (6) @(posedge CLK);
        TEMP_ALERT <= 1'b0;
        REG_LOW_ALERT <= 1'b0;
        repeat (6) @(posedge CLK);
        chk(IRQ, 1'b0, "irq held");
        wr(12'h048, 32'h0, 2'b00);
        repeat (2) @(posedge CLK);
        chk(IRQ, 1'b1, "irq on");
        wr(12'h04c, 32'h9001, 2'b00);
        repeat (2) @(posedge CLK);
        chk(IRQ, 1'b0, "irq masked");
        wr(12'h04c, 32'h0, 2'b00);
        rds(16'h9001);
        repeat (2) @(posedge CLK);
        chk(IRQ, 1'b0, "irq cleared");
        rds(16'h0);
        // output roles: codes b, 7, 3, 9, 2 with random inversion
        TEMP_ALERT <= 1'b1;
        REG_LOW_ALERT <= 1'b1;
        for (int f = 0; f < 5; f++) begin
            inv = $random(seed);
            v = 20'h2937b >> (4 * f);
            wr(12'h038, {21'h0, inv, 6'h0, v[3:0]}, 2'b00);
            repeat (2) @(posedge CLK);
            chk(PIN_B_OUT, (f > 2 ? src_q[f[0]] : 1'b1) ^ inv, "role out");
        end
        TEMP_ALERT <= 1'b0;
        REG_LOW_ALERT <= 1'b0;
        rds(16'h8001);
        wr(12'h02c, 32'h0, 2'b00);
        rd(12'h02c, d, 2'b00);
        chk(d, 32'h1, "select latch");
        // second reset in mid-run returns select and control to defaults
        SYS_RST <= 1'b1;
        repeat (4) @(posedge CLK);
        SYS_RST <= 1'b0;
        @(posedge CLK);
        rd(12'h02c, d, 2'b00);
        chk(d, 32'h0, "select reset");
        rd(12'h038, d, 2'b00);
        chk(d, 32'h0000c000, "ctrl re-reset");
        test_done;
    end

    initial begin
        #200000;
        n_errors++;
        test_done;
    end
endmodule : test_pcis_top
